// File: hw/acfg_pkg.sv
// ==========================================================
// Serial configuration decoder constants
// ==========================================================
package acfg_pkg;

  // Frame shape
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned CNT_W         = 5;
  localparam logic [4:0]  CNT_FULL      = 5'h10;
  localparam logic [4:0]  CNT_EDGE14    = 5'h0E;
  localparam logic [4:0]  CNT_EDGE15    = 5'h0F;

  // Header positions in the frame
  localparam int unsigned FRM_WRITE     = 15;
  localparam int unsigned FRM_ZERO      = 14;
  localparam int unsigned FRM_SEL       = 13;

  // Control register slice of the frame
  localparam int unsigned CTL_W         = 12;
  localparam int unsigned CTL_FRM_LSB   = 1;

  // Fields inside the control register
  localparam int unsigned CTL_CHAN      = 9;
  localparam int unsigned CTL_MODE_LSB  = 7;
  localparam int unsigned CTL_PWR_LSB   = 5;
  localparam int unsigned CTL_CODING    = 4;
  localparam int unsigned CTL_REF       = 3;
  localparam int unsigned CTL_SEQ_LSB   = 1;

  // Power bits position in the frame
  localparam int unsigned FRM_PWR_LSB   = 6;

  // Range register slice of the frame
  localparam int unsigned RNG_W         = 6;
  localparam int unsigned RNG_FRM_LSB   = 7;
  localparam int unsigned RNG_CH0_LSB   = 4;
  localparam int unsigned RNG_CH1_LSB   = 0;

  // Values after reset
  localparam logic [11:0] CTL_RESET     = 12'h000;
  localparam logic [5:0]  RNG_RESET     = 6'h00;

  // Header codes
  localparam logic [2:0]  HDR_CTRL      = 3'h4;
  localparam logic [2:0]  HDR_RANGE     = 3'h5;

  // Power selections
  localparam logic [1:0]  PWR_NORMAL    = 2'h0;
  localparam logic [1:0]  PWR_AUTO_STBY = 2'h1;
  localparam logic [1:0]  PWR_AUTO_SHUT = 2'h2;
  localparam logic [1:0]  PWR_FULL_SHUT = 2'h3;

  // Input configurations
  localparam logic [1:0]  MODE_SINGLE   = 2'h0;

  // Sequencer flags that enable sequencing
  localparam logic [1:0]  SEQ_RUN       = 2'h2;

  // Power state of the converter core
  typedef enum logic [1:0] {
    ACFG_ST_ON        = 2'b00,
    ACFG_ST_STANDBY   = 2'b01,
    ACFG_ST_AUTO_DOWN = 2'b10,
    ACFG_ST_FULL_DOWN = 2'b11
  } acfg_pwr_t;

endpackage

// File: hw/acfg_decoder.sv
`timescale 1ns/1ps
module acfg_decoder
  import acfg_pkg::*;
(
  // Core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Serial link from the host
  input  wire logic       sclk,
  input  wire logic       frame_sync_n,
  input  wire logic       din,
  // Conversion request from the converter core
  input  wire logic       conv_start,
  // Live configuration
  output logic [CTL_W-1:0] conversion_control,
  output logic [1:0]      range_ch0,
  output logic [1:0]      range_ch1,
  output logic            seq_active,
  // Settings latched for the conversion in progress
  output logic            conv_channel,
  output logic            conv_coding,
  output logic            conv_internal_ref,
  output logic [1:0]      conv_range,
  output logic            mux_pos_input_one,
  output logic            mux_neg_input_one,
  output logic            mux_neg_ground,
  // Power control and frame error flag
  output logic            core_powered,
  output logic            ref_powered,
  output logic            frame_invalid
);

  // ========================================================
  // Helper functions
  // ========================================================

  // Sequencer enabled for a control value
  function automatic logic seq_on(input logic [CTL_W-1:0] c);
    seq_on = (c[CTL_SEQ_LSB +: 2] == SEQ_RUN);
  endfunction

  // Range field for a channel
  function automatic logic [1:0] range_of(input logic [RNG_W-1:0] r, input logic ch);
    range_of = ch ? r[RNG_CH1_LSB +: 2] : r[RNG_CH0_LSB +: 2];
  endfunction

  // ========================================================
  // Link domain (serial clock)
  // ========================================================

  logic [FRAME_BITS-1:0] link_word;
  logic [CNT_W-1:0]      link_cnt;
  logic                  link_auto_hit;
  logic                  link_auto_shut;
  logic                  link_done;
  logic                  link_first;
  logic                  link_is_ctrl;
  logic [1:0]            link_pwr;
  logic [FRAME_BITS-2:0] next_partial;

  // Frame as it will stand after the edge now being taken
  assign next_partial = {link_word[FRAME_BITS-3:0], din};
  // First edge of a frame clears the done and auto hit flags of the previous one
  assign link_first   = (link_cnt == CNT_W'(0));
  // Header and power bits of a control write, one edge before the end
  assign link_is_ctrl = (next_partial[FRM_SEL-1 +: 3] == HDR_CTRL);
  assign link_pwr     = next_partial[FRM_PWR_LSB-1 +: 2];

  // Bit counter, ended by the frame sync going high
  always_ff @(posedge sclk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      link_cnt <= '0;
    end else if (link_cnt != CNT_FULL) begin
      link_cnt <= link_cnt + CNT_W'(1);
    end
  end

  // Shift register, first bit ends up at the top
  always_ff @(posedge sclk) begin
    if (!frame_sync_n && link_cnt != CNT_FULL) begin
      link_word <= {link_word[FRAME_BITS-2:0], din};
    end
  end

  // Auto power request seen on the fifteenth edge. The flag is a level that
  // lasts until the next frame opens, so a frame select that rises right after
  // the last edge cannot shrink it below what the core-side stages can catch.
  // The core reset also clears it; apply reset only while the link is idle.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      link_auto_hit  <= 1'b0;
      link_auto_shut <= 1'b0;
    end else if (!frame_sync_n) begin
      if (link_first) begin
        link_auto_hit <= 1'b0;
      end else if (link_cnt == CNT_EDGE14) begin
        link_auto_hit  <= link_is_ctrl &&
                          ((link_pwr == PWR_AUTO_SHUT) ||
                           (link_pwr == PWR_AUTO_STBY));
        // Mode kind stays put until the next frame, long after the core reads it
        link_auto_shut <= (link_pwr == PWR_AUTO_SHUT);
      end
    end
  end

  // Complete frame flag: set on the sixteenth edge, held until the next frame
  // opens, so the core sees it however soon the frame select goes high. A
  // stale level cleared by reset cannot come back as a false frame afterwards.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      link_done <= 1'b0;
    end else if (!frame_sync_n) begin
      if (link_first) begin
        link_done <= 1'b0;
      end else if (link_cnt == CNT_EDGE15) begin
        link_done <= 1'b1;
      end
    end
  end

  // ========================================================
  // Crossing into the core domain
  // ========================================================

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic [2:0] sync_lvl;
  logic [2:0] sync_prev;
  logic       done_rise;
  logic       auto_rise;
  logic       frame_rise;

  // Three stages: done, auto hit, frame active
  always_ff @(posedge core_clk) begin
    sync_a <= {~frame_sync_n, link_auto_hit, link_done};
    sync_b <= sync_a;
    sync_c <= sync_b;
  end

  // Accept a level once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_lvl  <= 3'h0;
      sync_prev <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          sync_lvl[i] <= sync_c[i];
        end
      end
      sync_prev <= sync_lvl;
    end
  end

  // Rising edges of the accepted levels
  assign done_rise  = sync_lvl[0] && !sync_prev[0];
  assign auto_rise  = sync_lvl[1] && !sync_prev[1];
  assign frame_rise = sync_lvl[2] && !sync_prev[2];

  // ========================================================
  // Frame decode
  // ========================================================

  logic [2:0] hdr;
  logic       ctrl_load;
  logic       range_load;
  logic       bad_frame;

  // The frame word crosses without stages of its own: it stands still from
  // the sixteenth edge until the next frame opens, and is read only at the
  // synchronised done edge, several core cycles after it settled.
  assign hdr        = link_word[FRM_SEL +: 3];
  assign ctrl_load  = done_rise && (hdr == HDR_CTRL);
  assign range_load = done_rise && (hdr == HDR_RANGE);
  assign bad_frame  = done_rise && link_word[FRM_WRITE] &&
                      link_word[FRM_ZERO];

  // ========================================================
  // Configuration registers (no readback path)
  // ========================================================

  // Control register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conversion_control <= CTL_RESET;
    end else if (ctrl_load) begin
      conversion_control <= link_word[CTL_FRM_LSB +: CTL_W];
    end
  end

  // Range register, default plus/minus ten volts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      range_ch0 <= RNG_RESET[RNG_CH0_LSB +: 2];
      range_ch1 <= RNG_RESET[RNG_CH1_LSB +: 2];
    end else if (range_load) begin
      range_ch0 <= link_word[RNG_FRM_LSB+RNG_CH0_LSB +: 2];
      range_ch1 <= link_word[RNG_FRM_LSB+RNG_CH1_LSB +: 2];
    end
  end

  // Held until the next complete frame: last frame had its write and zero bits both set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_invalid <= 1'b0;
    end else if (done_rise) begin
      frame_invalid <= bad_frame;
    end
  end

  // Sequencer state follows the control register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_active <= 1'b0;
    end else if (ctrl_load) begin
      seq_active <= seq_on(link_word[CTL_FRM_LSB +: CTL_W]);
    end
  end

  // ========================================================
  // Conversion snapshot and sequencer
  // ========================================================

  logic       seq_pos;
  logic       next_chan;
  logic [1:0] cur_mode;
  logic       conv_ok;

  assign cur_mode = conversion_control[CTL_MODE_LSB +: 2];
  assign conv_ok  = conv_start && core_powered;

  // Channel for this conversion
  always_comb begin
    if (seq_on(conversion_control)) begin
      next_chan = seq_pos;
    end else begin
      next_chan = conversion_control[CTL_CHAN];
    end
  end

  // Sequence position restarts on each control write
  always_ff @(posedge core_clk) begin
    if (rst || ctrl_load) begin
      seq_pos <= 1'b0;
    end else if (conv_ok && seq_on(conversion_control)) begin
      if (seq_pos == conversion_control[CTL_CHAN]) begin
        seq_pos <= 1'b0;
      end else begin
        seq_pos <= seq_pos + 1'b1;
      end
    end
  end

  // Settings frozen at conversion start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_channel      <= 1'b0;
      conv_coding       <= 1'b0;
      conv_internal_ref <= 1'b0;
      conv_range        <= RNG_RESET[RNG_CH0_LSB +: 2];
      mux_pos_input_one <= 1'b0;
      mux_neg_input_one <= 1'b0;
      mux_neg_ground    <= 1'b1;
    end else if (conv_ok) begin
      conv_channel      <= next_chan;
      conv_coding       <= conversion_control[CTL_CODING];
      conv_internal_ref <= conversion_control[CTL_REF];
      conv_range        <= range_of({range_ch0, 2'h0, range_ch1}, next_chan);
      if (cur_mode == MODE_SINGLE) begin
        mux_pos_input_one <= next_chan;
        mux_neg_input_one <= 1'b0;
        mux_neg_ground    <= 1'b1;
      end else begin
        mux_pos_input_one <= 1'b0;
        mux_neg_input_one <= 1'b1;
        mux_neg_ground    <= 1'b0;
      end
    end
  end

  // ========================================================
  // Power management
  // ========================================================

  acfg_pwr_t  pwr_st;
  acfg_pwr_t  next_pwr;

  // Power state transitions. Auto modes start from the link flag at edge
  // fifteen; full shutdown and normal mode start from the load at frame end.
  always_comb begin
    next_pwr = pwr_st;
    case (pwr_st)
      ACFG_ST_ON: begin
        if (auto_rise && link_auto_shut) begin
          next_pwr = ACFG_ST_AUTO_DOWN;
        end else if (auto_rise) begin
          next_pwr = ACFG_ST_STANDBY;
        end
      end
      ACFG_ST_STANDBY, ACFG_ST_AUTO_DOWN: begin
        // Wake only when a new frame opens, not on the one that asked for sleep
        if (frame_rise) begin
          next_pwr = ACFG_ST_ON;
        end
      end
      ACFG_ST_FULL_DOWN: begin
        next_pwr = ACFG_ST_FULL_DOWN;
      end
      default: begin
        next_pwr = ACFG_ST_ON;
      end
    endcase
    if (ctrl_load) begin
      case (link_word[FRM_PWR_LSB +: 2])
        PWR_FULL_SHUT: next_pwr = ACFG_ST_FULL_DOWN;
        PWR_NORMAL:    next_pwr = ACFG_ST_ON;
        default:       next_pwr = pwr_st;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_st <= ACFG_ST_ON;
    end else begin
      pwr_st <= next_pwr;
    end
  end

  // Registered supply enables
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_powered <= 1'b1;
      ref_powered  <= 1'b0;
    end else begin
      core_powered <= (next_pwr == ACFG_ST_ON);
      ref_powered  <= conversion_control[CTL_REF] &&
                      (next_pwr == ACFG_ST_ON ||
                       next_pwr == ACFG_ST_STANDBY);
    end
  end

endmodule // acfg_decoder

// File: sim/acfg_host_model.sv
`timescale 1ns/1ps
// =====
// Host serial master
module acfg_host_model (
  // Serial link to the device
  output logic sclk,
  output logic frame_sync_n,
  output logic din
);
  // Link idle: clock still, frame closed
  initial begin
    sclk         = 1'b0;
    frame_sync_n = 1'b1;
    din          = 1'b0;
  end
  // Shift n bits MSB first at 80 ns per bit
  task automatic send(input logic [15:0] w, input int n);
    int i;
    #7;
    frame_sync_n = 1'b0;
    for (i = 0; i < n; i++) begin
      din = w[15-i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #20 din = ~din;    // Released line shows no stale bit
    frame_sync_n = 1'b1;
    #200;
  endtask
endmodule // acfg_host_model

// File: sim/acfg_decoder_sva.sv
`timescale 1ns/1ps
// =====
// Port checker
module acfg_decoder_sva
  import acfg_pkg::*;
(
  // Clock, reset, link
  input wire logic core_clk, rst, sclk, frame_sync_n, din, conv_start,
  // Configuration
  input wire logic [CTL_W-1:0] conversion_control,
  input wire logic [1:0]       range_ch0, range_ch1, conv_range,
  // Conversion, power and frame error flag
  input wire logic seq_active, conv_channel, conv_coding, conv_internal_ref,
  input wire logic mux_pos_input_one, mux_neg_input_one, mux_neg_ground,
  input wire logic core_powered, ref_powered, frame_invalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Accepted conversion request
  logic take;
  assign take = conv_start && core_powered;
  // =====
  // Assertions
  ctl_reset_a: assert property (disable iff (1'b0)
    rst |=> conversion_control == CTL_RESET) else $error("control not cleared");
  rng_reset_a: assert property (disable iff (1'b0)
    rst |=> range_ch0 == 2'h0 && range_ch1 == 2'h0) else $error("range not cleared");
  conv_coding_a: assert property (
    take |=> conv_coding == $past(conversion_control[CTL_CODING])) else $error("coding");
  conv_ref_a: assert property (
    take |=> conv_internal_ref == $past(conversion_control[CTL_REF])) else $error("ref");
  conv_chan_a: assert property (
    take && !seq_active |=> conv_channel == $past(conversion_control[CTL_CHAN]))
    else $error("channel");
  conv_range_a: assert property (
    take |=> conv_range == (conv_channel ? $past(range_ch1) : $past(range_ch0)))
    else $error("range");
  mux_single_a: assert property (
    take && conversion_control[CTL_MODE_LSB+:2] == MODE_SINGLE |=> mux_neg_ground
    && !mux_neg_input_one && mux_pos_input_one == conv_channel) else $error("single");
  mux_diff_a: assert property (
    take && conversion_control[CTL_MODE_LSB+:2] != MODE_SINGLE |=> !mux_neg_ground
    && mux_neg_input_one && !mux_pos_input_one) else $error("differential");
  full_down_a: assert property (
    conversion_control[CTL_PWR_LSB+:2] == PWR_FULL_SHUT [*3] |-> !core_powered
    && !ref_powered) else $error("full shutdown");
  invalid_hold_a: assert property (
    $rose(frame_invalid) |-> $stable(conversion_control) && $stable(range_ch0))
    else $error("invalid frame loaded");
  // Main scenarios
  seq_c: cover property (take && seq_active);
  down_c: cover property (conv_start && !core_powered);
  inv_c: cover property ($rose(frame_invalid));
endmodule // acfg_decoder_sva

// File: sim/acfg_decoder_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: %0h vs %0h", $time, (a), (e)); end end
// =====
// Bench top
module acfg_decoder_tb
  import acfg_pkg::*;
;
  logic             core_clk, rst, conv_start, sclk, frame_sync_n, din;
  logic [CTL_W-1:0] conversion_control;
  logic [1:0]       range_ch0, range_ch1, conv_range;
  logic             seq_active, conv_channel, conv_coding, conv_internal_ref;
  logic             mux_pos_input_one, mux_neg_input_one, mux_neg_ground;
  logic             core_powered, ref_powered, frame_invalid;
  int               errors = 0;
  int               n_compared = 0;
  // Device and host
  acfg_decoder dut_u (.core_clk(core_clk), .rst(rst), .sclk(sclk),
    .frame_sync_n(frame_sync_n), .din(din), .conv_start(conv_start),
    .conversion_control(conversion_control), .range_ch0(range_ch0),
    .range_ch1(range_ch1), .seq_active(seq_active), .conv_channel(conv_channel),
    .conv_coding(conv_coding), .conv_internal_ref(conv_internal_ref),
    .conv_range(conv_range), .mux_pos_input_one(mux_pos_input_one),
    .mux_neg_input_one(mux_neg_input_one), .mux_neg_ground(mux_neg_ground),
    .core_powered(core_powered), .ref_powered(ref_powered),
    .frame_invalid(frame_invalid));
  acfg_host_model host_u (.sclk(sclk), .frame_sync_n(frame_sync_n), .din(din));
  // Core clock 40 ns
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // One frame, then room for the crossing
  task automatic wr(input logic [15:0] f, input int n = 16);
    host_u.send(f, n);
    repeat (3) @(negedge core_clk);
  endtask
  function automatic logic [15:0] cf(input logic [11:0] c);
    return {3'b100, c, 1'b0};
  endfunction
  // One conversion request
  task automatic conv;
    conv_start = 1'b1;
    @(negedge core_clk);
    conv_start = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    errors++;
    test_done();
  end
  // =====
  // Tests
  initial begin
    int i;
    rst = 1'b1;
    conv_start = 1'b0;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    `CHK(conversion_control, 12'h000)
    `CHK({range_ch0, range_ch1}, 4'h0)
    `CHK({core_powered, seq_active, frame_invalid}, 3'h4)
    // Every span on both channels, range first
    for (i = 0; i < 4; i++) begin
      wr({3'b101, i[1:0], 2'b00, ~i[1:0], 7'h00});
      `CHK(range_ch0, i[1:0])
      `CHK(range_ch1, ~i[1:0])
      `CHK(conversion_control, 12'h000)
    end
    wr({3'b101, 2'b01, 2'b00, 2'b10, 7'h00});
    // Single-ended, channel one
    wr(cf(12'h218));
    `CHK(conversion_control, 12'h218)
    conv;
    `CHK({conv_channel, conv_coding, conv_internal_ref}, 3'h7)
    `CHK(conv_range, 2'h2)
    `CHK({mux_pos_input_one, mux_neg_input_one, mux_neg_ground}, 3'h5)
    // Refused frames
    wr(16'h3FFE);
    `CHK(conversion_control, 12'h218)
    wr(16'hC000);
    `CHK(conversion_control, 12'h218)
    `CHK(frame_invalid, 1'b1)
    wr(cf(12'h000), 15);
    `CHK(conversion_control, 12'h218)
    // New settings wait for the next conversion
    wr(cf(12'h100));
    `CHK(conv_coding, 1'b1)
    conv;
    `CHK({conv_coding, conv_internal_ref, conv_range}, 4'h1)
    for (i = 1; i < 3; i++) begin
      wr(cf({2'b00, 1'b1, i[1:0], 7'h00}));
      conv;
      `CHK({mux_pos_input_one, mux_neg_input_one, mux_neg_ground}, 3'h2)
    end
    // Sequencer up to channel one
    wr(cf(12'h21C));
    `CHK(seq_active, 1'b1)
    for (i = 0; i < 3; i++) begin
      conv;
      `CHK({conv_channel, conv_coding, conv_internal_ref}, {i[0], 2'b11})
    end
    wr(cf(12'h206));
    conv;
    `CHK({seq_active, conv_channel}, 2'h1)
    // Power modes
    wr(cf(12'h060));
    `CHK({core_powered, ref_powered}, 2'h0)
    `CHK(conversion_control, 12'h060)
    conv;
    `CHK(conv_channel, 1'b1)
    wr(cf(12'h000));
    `CHK(core_powered, 1'b1)
    // Auto shutdown then auto standby, reference bit set: the reference goes down only in shutdown
    wr(cf(12'h048));
    `CHK({core_powered, ref_powered}, 2'h0)
    wr(cf(12'h028));
    `CHK({core_powered, ref_powered}, 2'h1)
    test_done();
  end
endmodule // acfg_decoder_tb

bind acfg_decoder acfg_decoder_sva chk_u (.core_clk(core_clk), .rst(rst), .sclk(sclk),
  .frame_sync_n(frame_sync_n), .din(din), .conv_start(conv_start),
  .conversion_control(conversion_control), .range_ch0(range_ch0),
  .range_ch1(range_ch1), .conv_range(conv_range), .seq_active(seq_active),
  .conv_channel(conv_channel), .conv_coding(conv_coding),
  .conv_internal_ref(conv_internal_ref), .mux_pos_input_one(mux_pos_input_one),
  .mux_neg_input_one(mux_neg_input_one), .mux_neg_ground(mux_neg_ground),
  .core_powered(core_powered), .ref_powered(ref_powered),
  .frame_invalid(frame_invalid));
